// ===== core/dual_timer_counter.sv
/*
 dual_timer_counter: two 16-bit timer/counters with shared mode control,
 run/overflow flags, prescale selects and a maskable interrupt, on APB.
 assumes: pclk is also the crystal reference; count and gate pins are
 asynchronous and are synchronised here.
*/
// The APB register port was decided locally.
// Functional notes
// [R1] timer 1 gate bit clear: timer 1 runs on its run bit alone
// [R2] timer 1 gate bit set: needs run bit and gate line high
// [R3] timer 1 source: internal tick or falling edges on its count pin
// [R4] mode 00 is 8 bits with 5-bit prescaler, mode 01 16 bits
// [R5] mode 10 is an 8-bit counter with automatic reload
// [R6] timer 0 mode 11 splits it and stops timer 1; timer 1 mode 11 halts
// [R7] timer 0 gate bit set also requires its gate line high
// [R8] timer 0 source: internal tick or falling edges on its count pin
// [R9] timer 0 low byte readable and writable, write loads the count
// [R10] timer 1 low byte readable and writable, write loads the count
// [R11] timer 0 high byte readable and writable, write loads the count
// [R12] timer 1 high byte readable and writable, write loads the count
// [R13] internal tick is crystal divided by 12, or system clock by 4
// [R14] reload mode copies high byte into low byte on low overflow
// [R15] overflow sets the flag; split high byte uses timer 1 run and flag
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic count_pin0,
   input wire logic count_pin1,
   input wire logic ext_gate_line0_n,
   input wire logic ext_gate_line1_n,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // state
   timer_pkg::mode_reg_t mode_reg;
   logic [7:0] t0_low_reg;
   logic [7:0] t0_high_reg;
   logic [7:0] t1_low_reg;
   logic [7:0] t1_high_reg;
   logic tr0_reg;
   logic tr1_reg;
   logic tf0_reg;
   logic tf1_reg;
   logic presc0_reg;
   logic presc1_reg;
   logic [1:0] int_status_reg;
   logic [1:0] int_mask_reg;

   logic xtal_tick;
   logic sys_tick;
   logic cnt0_lvl;
   logic cnt0_fall;
   logic cnt1_lvl;
   logic cnt1_fall;
   logic gate0_lvl;
   logic gate1_lvl;

   ////////////////////////////////////////////////////////////////////////
   // tick sources and pin synchronisers
   tick_divider #(.DIV(timer_pkg::XTAL_DIV)) u_xtal_div (
      .pclk(pclk),
      .presetn(presetn),
      .tick(xtal_tick)
   );

   tick_divider #(.DIV(timer_pkg::SYS_DIV)) u_sys_div (
      .pclk(pclk),
      .presetn(presetn),
      .tick(sys_tick)
   );

   pin_sync u_cnt0 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(count_pin0),
      .level(cnt0_lvl),
      .fall(cnt0_fall)
   );

   pin_sync u_cnt1 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(count_pin1),
      .level(cnt1_lvl),
      .fall(cnt1_fall)
   );

   // gate lines need only a level, the edge output stays unused
   pin_sync u_gate0 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(ext_gate_line0_n),
      .level(gate0_lvl),
      .fall()
   );

   pin_sync u_gate1 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(ext_gate_line1_n),
      .level(gate1_lvl),
      .fall()
   );

   ////////////////////////////////////////////////////////////////////////
   // one count step: {overflow, high, low}
   function automatic logic [16:0] count_step(
      input timer_pkg::timer_mode_t m,
      input logic [7:0] lo,
      input logic [7:0] hi
   );
      logic carry;
      logic [16:0] r;
      carry = 1'b0;
      r = {1'b0, hi, lo};
      case (m)
         timer_pkg::MODE_13BIT: begin
            carry = (lo[4:0] == timer_pkg::PRESCALE_MAX);
            r[4:0] = lo[4:0] + 5'h01; // R4
            r[15:8] = carry ? hi + 8'h01 : hi;
            r[16] = carry & (hi == timer_pkg::BYTE_MAX);
         end
         timer_pkg::MODE_16BIT: begin
            r = {1'b0, hi, lo} + 17'h00001; // R4
         end
         timer_pkg::MODE_RELOAD: begin
            carry = (lo == timer_pkg::BYTE_MAX);
            r[7:0] = carry ? hi : lo + 8'h01; // R5 R14
            r[16] = carry;
         end
         timer_pkg::MODE_SPLIT: begin
            r[7:0] = lo + 8'h01;
            r[16] = (lo == timer_pkg::BYTE_MAX);
         end
         default: begin
            r = {1'b0, hi, lo};
         end
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // count enables
   timer_pkg::timer_cfg_t cfg0;
   timer_pkg::timer_cfg_t cfg1;
   logic t0_tick;
   logic t1_tick;
   logic t0_inc;
   logic t1_inc;
   logic t0_split;
   logic t1_halt;
   logic th0_inc;
   logic [16:0] t0_step;
   logic [16:0] t1_step;
   logic tf0_set;
   logic tf1_set;

   assign cfg0 = mode_reg.t0;
   assign cfg1 = mode_reg.t1;
   assign t0_tick = presc0_reg ? sys_tick : xtal_tick; // R13
   assign t1_tick = presc1_reg ? sys_tick : xtal_tick; // R13
   assign t0_split = (cfg0.mode == timer_pkg::MODE_SPLIT);
   assign t1_halt = t0_split | (cfg1.mode == timer_pkg::MODE_SPLIT); // R6
   assign t0_inc = tr0_reg & (~cfg0.gate | gate0_lvl) // R7
      & (cfg0.count_src ? cnt0_fall : t0_tick); // R8
   assign t1_inc = tr1_reg & (~cfg1.gate | gate1_lvl) // R1 R2
      & (cfg1.count_src ? cnt1_fall : t1_tick) & ~t1_halt; // R3 R6
   // split high byte borrows timer 1's run bit and counts on timer 0's internal tick
   assign th0_inc = t0_split & tr1_reg & t0_tick; // R6 R15
   assign t0_step = count_step(cfg0.mode, t0_low_reg, t0_high_reg);
   assign t1_step = count_step(cfg1.mode, t1_low_reg, t1_high_reg);
   assign tf0_set = t0_inc & t0_step[16]; // R15
   assign tf1_set = (t1_inc & t1_step[16]) // R15
      | (th0_inc & (t0_high_reg == timer_pkg::BYTE_MAX)); // R15

   ////////////////////////////////////////////////////////////////////////
   // apb decode; writes land at the access edge only
   logic [9:0] idx;
   logic wr_en;
   logic hit;
   logic [7:0] rd_byte;

   assign idx = paddr[11:2];
   assign wr_en = psel & penable & pwrite & pready;

   always_comb begin
      hit = (paddr[1:0] == 2'h0);
      rd_byte = 8'h00;
      case (idx)
         timer_pkg::IDX_FLAGS: begin
            rd_byte[timer_pkg::FLAG_TF1] = tf1_reg;
            rd_byte[timer_pkg::FLAG_TR1] = tr1_reg;
            rd_byte[timer_pkg::FLAG_TF0] = tf0_reg;
            rd_byte[timer_pkg::FLAG_TR0] = tr0_reg;
         end
         timer_pkg::IDX_MODE: rd_byte = mode_reg;
         timer_pkg::IDX_T0_LOW: rd_byte = t0_low_reg; // R9
         timer_pkg::IDX_T1_LOW: rd_byte = t1_low_reg; // R10
         timer_pkg::IDX_T0_HIGH: rd_byte = t0_high_reg; // R11
         timer_pkg::IDX_T1_HIGH: rd_byte = t1_high_reg; // R12
         timer_pkg::IDX_PRESCALE: begin
            rd_byte[timer_pkg::PRESC_T1] = presc1_reg;
            rd_byte[timer_pkg::PRESC_T0] = presc0_reg;
         end
         timer_pkg::IDX_INT_STATUS: rd_byte[1:0] = int_status_reg;
         timer_pkg::IDX_INT_MASK: rd_byte[1:0] = int_mask_reg;
         default: hit = 1'b0;
      endcase
      if (!hit) begin
         rd_byte = 8'h00;
      end
   end

   // one wait-free access phase: answer prepared during the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         if (psel && !penable) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= timer_pkg::MODE_RST;
         presc0_reg <= 1'b0;
         presc1_reg <= 1'b0;
         tr0_reg <= 1'b0;
         tr1_reg <= 1'b0;
         int_mask_reg <= timer_pkg::INT_RST;
      end else if (wr_en && paddr[1:0] == 2'h0) begin
         if (idx == timer_pkg::IDX_MODE) begin
            mode_reg <= pwdata[7:0];
         end
         if (idx == timer_pkg::IDX_PRESCALE) begin
            presc0_reg <= pwdata[timer_pkg::PRESC_T0];
            presc1_reg <= pwdata[timer_pkg::PRESC_T1];
         end
         if (idx == timer_pkg::IDX_FLAGS) begin
            tr0_reg <= pwdata[timer_pkg::FLAG_TR0];
            tr1_reg <= pwdata[timer_pkg::FLAG_TR1];
         end
         if (idx == timer_pkg::IDX_INT_MASK) begin
            int_mask_reg <= pwdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // overflow flags: hardware set wins over a software write
   logic wr_flags;
   assign wr_flags = wr_en & (paddr[1:0] == 2'h0) & (idx == timer_pkg::IDX_FLAGS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tf0_reg <= 1'b0;
         tf1_reg <= 1'b0;
      end else begin
         tf0_reg <= tf0_set | (wr_flags ? pwdata[timer_pkg::FLAG_TF0] : tf0_reg); // R15
         tf1_reg <= tf1_set | (wr_flags ? pwdata[timer_pkg::FLAG_TF1] : tf1_reg); // R15
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt: sticky status, write one to clear, set wins
   logic wr_status;
   logic [1:0] status_set;
   logic [1:0] status_clr;
   assign wr_status = wr_en & (paddr[1:0] == 2'h0) & (idx == timer_pkg::IDX_INT_STATUS);
   assign status_set = {tf1_set, tf0_set};
   assign status_clr = wr_status ? pwdata[1:0] : 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= timer_pkg::INT_RST;
         irq <= 1'b0;
      end else begin
         int_status_reg <= status_set | (int_status_reg & ~status_clr);
         irq <= |(int_status_reg & int_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // count bytes: a software write replaces that byte for the cycle
   logic wr_cnt;
   assign wr_cnt = wr_en & (paddr[1:0] == 2'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t0_low_reg <= timer_pkg::COUNT_RST;
         t0_high_reg <= timer_pkg::COUNT_RST;
      end else begin
         if (wr_cnt && idx == timer_pkg::IDX_T0_LOW) begin
            t0_low_reg <= pwdata[7:0]; // R9
         end else if (t0_inc) begin
            t0_low_reg <= t0_step[7:0];
         end
         if (wr_cnt && idx == timer_pkg::IDX_T0_HIGH) begin
            t0_high_reg <= pwdata[7:0]; // R11
         end else if (t0_split) begin
            if (th0_inc) begin
               t0_high_reg <= t0_high_reg + 8'h01; // R6
            end
         end else if (t0_inc) begin
            t0_high_reg <= t0_step[15:8];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t1_low_reg <= timer_pkg::COUNT_RST;
         t1_high_reg <= timer_pkg::COUNT_RST;
      end else begin
         if (wr_cnt && idx == timer_pkg::IDX_T1_LOW) begin
            t1_low_reg <= pwdata[7:0]; // R10
         end else if (t1_inc) begin
            t1_low_reg <= t1_step[7:0];
         end
         if (wr_cnt && idx == timer_pkg::IDX_T1_HIGH) begin
            t1_high_reg <= pwdata[7:0]; // R12
         end else if (t1_inc) begin
            t1_high_reg <= t1_step[15:8];
         end
      end
   end

   // count pin levels only matter through their edges
   logic unused_lvl;
   assign unused_lvl = cnt0_lvl ^ cnt1_lvl;

endmodule
`default_nettype wire

// ===== core/pin_sync.sv
/*
 pin_sync: two-flop synchroniser for an asynchronous pin, with a
 falling-edge pulse taken only from the second flop onward.
 assumes: pin pulses last at least two pclk periods each way.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic level,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // meta_reg feeds only sync_reg
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign fall = prev_reg & ~sync_reg;
endmodule
`default_nettype wire

// ===== core/tick_divider.sv
/*
 tick_divider: one-cycle tick every DIV clocks of pclk.
 assumes: DIV between 2 and 16.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int unsigned DIV = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   logic [3:0] cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 4'h0;
         tick <= 1'b0;
      end else if (cnt_reg == 4'(DIV - 1)) begin
         cnt_reg <= 4'h0;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== core/timer_pkg.sv
/*
 timer_pkg: register indexes, bit positions, reset values, divider counts
 and the mode types shared by the dual timer/counter block.
 assumes: byte address of a register is four times its index.
*/
package timer_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register indexes (byte address = index * 4)
   localparam logic [9:0] IDX_FLAGS = 10'h088;
   localparam logic [9:0] IDX_MODE = 10'h089;
   localparam logic [9:0] IDX_T0_LOW = 10'h08a;
   localparam logic [9:0] IDX_T1_LOW = 10'h08b;
   localparam logic [9:0] IDX_T0_HIGH = 10'h08c;
   localparam logic [9:0] IDX_T1_HIGH = 10'h08d;
   localparam logic [9:0] IDX_PRESCALE = 10'h08e;
   localparam logic [9:0] IDX_INT_STATUS = 10'h0a0;
   localparam logic [9:0] IDX_INT_MASK = 10'h0a1;

   ////////////////////////////////////////////////////////////////////////
   // bit positions
   localparam int unsigned FLAG_TF1 = 7;
   localparam int unsigned FLAG_TR1 = 6;
   localparam int unsigned FLAG_TF0 = 5;
   localparam int unsigned FLAG_TR0 = 4;
   localparam int unsigned PRESC_T1 = 4;
   localparam int unsigned PRESC_T0 = 3;
   localparam int unsigned INT_T0 = 0;
   localparam int unsigned INT_T1 = 1;

   ////////////////////////////////////////////////////////////////////////
   // reset values and counts
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [1:0] INT_RST = 2'h0;
   localparam int unsigned XTAL_DIV = 12;
   localparam int unsigned SYS_DIV = 4;
   localparam logic [4:0] PRESCALE_MAX = 5'h1f;
   localparam logic [7:0] BYTE_MAX = 8'hff;

   ////////////////////////////////////////////////////////////////////////
   // mode types
   typedef enum logic [1:0] {
      MODE_13BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } timer_mode_t;

   typedef struct packed {
      logic gate;
      logic count_src;
      timer_mode_t mode;
   } timer_cfg_t;

   typedef struct packed {
      timer_cfg_t t1;
      timer_cfg_t t0;
   } mode_reg_t;

endpackage

// ===== tb/dual_timer_counter_mode_control_tb.sv
/*
 dual_timer_counter_mode_control_tb: random mode, pin and prescale settings over both timers.
 assumes: dividers run free from reset; a 48-cycle run window.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_mode_control_tb;
   logic pclk, presetn, psel, penable, pwrite, go, g0, g1, e;
   logic cp0, cp1, gn0, gn1, pready, pslverr, irq;
   logic [2:0] p0, p1;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   int num_errors, n_checks;
   localparam logic [9:0] IX [5] = '{timer_pkg::IDX_MODE, timer_pkg::IDX_T0_LOW,
      timer_pkg::IDX_T1_LOW, timer_pkg::IDX_T0_HIGH, timer_pkg::IDX_T1_HIGH};
   localparam logic [7:0] CM [4] = '{8'h11, 8'h03, 8'h22, 8'h30};
   dual_timer_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_pin0(cp0), .count_pin1(cp1), .ext_gate_line0_n(gn0),
      .ext_gate_line1_n(gn1), .irq(irq));
   pulse_partner u_pins (.pclk(pclk), .presetn(presetn), .go(go), .n0(p0), .n1(p1), .g0(g0),
      .g1(g1), .count_pin0(cp0), .count_pin1(cp1), .ext_gate_line0_n(gn0), .ext_gate_line1_n(gn1));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 8);
      if (pready !== 1'b1) begin
         num_errors++;
         close_out();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      apb(1'b1, i, {24'h000000, d});
   endtask
   task automatic rc(input string s, input logic [9:0] i, input logic [7:0] x);
      apb(1'b0, i, 32'h00000000);
      chk(s, r, {24'h000000, x});
   endtask
   // the bench's own count model: returns {overflow, high, low}
   function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] h, l, input int n);
      logic o;
      o = 1'b0;
      repeat (n) begin
         case (m)
            2'b00: begin
               l[4:0] = l[4:0] + 5'h01;
               if (l[4:0] == 5'h00) begin
                  h = h + 8'h01;
                  o |= (h == 8'h00);
               end
            end
            2'b01: begin
               {h, l} = {h, l} + 16'h0001;
               o |= ({h, l} == 16'h0000);
            end
            2'b10: begin
               o |= (l == 8'hff);
               l = (l == 8'hff) ? h : l + 8'h01;
            end
            default: begin
               l = l + 8'h01;
               o |= (l == 8'h00);
            end
         endcase
      end
      return {o, h, l};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] md, pre;
      logic [7:0] v [4];
      logic [1:0] tr, gl, msk, ov;
      logic [16:0] s0, s1, sh;
      int c0, c1, i0, i1;
      {presetn, psel, penable, pwrite, go, g0, g1} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      p0 = 3'h0;
      p1 = 3'h0;
      num_errors = 0;
      n_checks = 0;
      void'($urandom(32'h8128));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 5; k++) rc("reset", IX[k], 8'h00);
      apb(1'b0, 10'h3ff, 32'h00000000);
      chk("unmapped error", {31'h0, e}, 32'h00000001);
      chk("unmapped data", r, 32'h00000000);
      for (int it = 0; it < 40; it++) begin
         md = 8'($urandom);
         pre = 8'($urandom) & 8'h18;
         tr = 2'($urandom);
         gl = 2'($urandom);
         msk = 2'($urandom);
         foreach (v[k]) v[k] = 8'($urandom);
         if (it < 4) begin
            md = CM[it];
            tr = 2'h3;
            foreach (v[k]) v[k] = 8'hff;
         end
         p0 <= 3'($urandom_range(4, 0));
         p1 <= 3'($urandom_range(4, 0));
         g0 <= gl[0];
         g1 <= gl[1];
         wr(IX[0], md);
         wr(timer_pkg::IDX_PRESCALE, pre);
         wr(timer_pkg::IDX_INT_MASK, {6'h00, msk});
         wr(timer_pkg::IDX_INT_STATUS, 8'h03);
         for (int k = 0; k < 4; k++) wr(IX[k + 1], v[k]);
         for (int k = 0; k < 4; k++) rc("count", IX[k + 1], v[k]);
         rc("mode", IX[0], md);
         rc("prescale", timer_pkg::IDX_PRESCALE, pre);
         rc("mask", timer_pkg::IDX_INT_MASK, {6'h00, msk});
         wr(timer_pkg::IDX_FLAGS, {1'b0, tr[1], 1'b0, tr[0], 4'h0});
         go <= 1'b1;
         @(posedge pclk);
         go <= 1'b0;
         repeat (44) @(posedge pclk);
         wr(timer_pkg::IDX_FLAGS, 8'h00);
         i0 = 48 / int'(pre[3] ? timer_pkg::SYS_DIV : timer_pkg::XTAL_DIV);
         i1 = 48 / int'(pre[4] ? timer_pkg::SYS_DIV : timer_pkg::XTAL_DIV);
         c0 = (tr[0] && (!md[3] || gl[0])) ? (md[2] ? int'(p0) : i0) : 0;
         c1 = (tr[1] && (!md[7] || gl[1]) && md[5:4] != 2'h3 && md[1:0] != 2'h3) ? (md[6] ? int'(p1) : i1) : 0;
         sh = step(2'h3, 8'h00, v[2], tr[1] ? i0 : 0);
         if (md[1:0] == 2'h3) s0 = {step(2'h3, 8'h00, v[0], c0)} | {1'b0, sh[7:0], 8'h00};
         else s0 = step(md[1:0], v[2], v[0], c0);
         if (md[1:0] != 2'h3) sh = 17'h00000;
         s1 = step(md[5:4], v[3], v[1], c1);
         rc("t0 low", IX[1], s0[7:0]);
         rc("t1 low", IX[2], s1[7:0]);
         rc("t0 high", IX[3], s0[15:8]);
         rc("t1 high", IX[4], s1[15:8]);
         ov = {s1[16] | sh[16], s0[16]};
         rc("status", timer_pkg::IDX_INT_STATUS, {6'h00, ov});
         chk("irq", {31'h0, irq}, {31'h0, |(ov & msk)});
         wr(timer_pkg::IDX_INT_STATUS, 8'h03);
         repeat (2) @(posedge pclk);
         chk("irq cleared", {31'h0, irq}, 32'h00000000);
      end
      close_out();
   end
endmodule
`default_nettype wire

// ===== tb/pulse_partner.sv
/*
 pulse_partner: drives the timer count pins and gate lines.
 assumes: go is a one-cycle strobe; pulse counts 0 to 4.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic [2:0] n0,
   input wire logic [2:0] n1,
   input wire logic g0,
   input wire logic g1,
   output logic count_pin0,
   output logic count_pin1,
   output logic ext_gate_line0_n,
   output logic ext_gate_line1_n
);
   logic [5:0] t;
   logic act;
   ////////////////////////////////////////////////////////////////////////
   // 4 low then 4 high per pulse, twice the minimum the sync needs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t <= 6'h00;
         act <= 1'b0;
      end else if (go) begin
         t <= 6'h00;
         act <= 1'b1;
      end else if (act) begin
         t <= t + 6'h01;
         act <= (t != 6'h27);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_gate_line0_n <= 1'b1;
         ext_gate_line1_n <= 1'b1;
      end else begin
         ext_gate_line0_n <= g0;
         ext_gate_line1_n <= g1;
      end
   end
   assign count_pin0 = !(act && !t[2] && t[5:3] < n0);
   assign count_pin1 = !(act && !t[2] && t[5:3] < n1);
endmodule
`default_nettype wire

// ===== tb/timer_props.sv
/*
 timer_props: bus-side checks of the dual timer block.
 assumes: bound to dual_timer_counter; only software writes mode and run bits.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   localparam logic [11:0] A_FL = {timer_pkg::IDX_FLAGS, 2'b00};
   localparam logic [11:0] A_MD = {timer_pkg::IDX_MODE, 2'b00};
   localparam logic [11:0] A_T0L = {timer_pkg::IDX_T0_LOW, 2'b00};
   localparam logic [11:0] A_T1L = {timer_pkg::IDX_T1_LOW, 2'b00};
   localparam logic [11:0] A_T0H = {timer_pkg::IDX_T0_HIGH, 2'b00};
   localparam logic [11:0] A_T1H = {timer_pkg::IDX_T1_HIGH, 2'b00};
   logic wa, ra, tr0_sh, tr1_sh, v0, v1;
   logic [7:0] md_sh, t0l_sh, t1h_sh;
   assign wa = psel & penable & pready & pwrite;
   assign ra = psel & penable & pready & ~pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   // shadows; a count shadow goes stale once its run bit may be set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         md_sh <= 8'h00;
         tr0_sh <= 1'b0;
         tr1_sh <= 1'b0;
      end else if (wa && paddr == A_MD) begin
         md_sh <= pwdata[7:0];
      end else if (wa && paddr == A_FL) begin
         tr0_sh <= pwdata[4];
         tr1_sh <= pwdata[6];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         v0 <= 1'b0;
         t0l_sh <= 8'h00;
      end else if (wa && paddr == A_T0L) begin
         v0 <= !tr0_sh;
         t0l_sh <= pwdata[7:0];
      end else if (tr0_sh) begin
         v0 <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         v1 <= 1'b0;
         t1h_sh <= 8'h00;
      end else if (wa && paddr == A_T1H) begin
         v1 <= !tr1_sh;
         t1h_sh <= pwdata[7:0];
      end else if (tr1_sh) begin
         v1 <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_t0l_ack;
      psel && !penable && paddr == A_T0L |=> pready && !pslverr;
   endproperty
   a_t0l_ack: assert property (p_t0l_ack) else $error("t0 low not answered");
   property p_t1l_ack;
      psel && !penable && paddr == A_T1L |=> pready && !pslverr;
   endproperty
   a_t1l_ack: assert property (p_t1l_ack) else $error("t1 low not answered");
   property p_t0h_ack;
      psel && !penable && paddr == A_T0H |=> pready && !pslverr;
   endproperty
   a_t0h_ack: assert property (p_t0h_ack) else $error("t0 high not answered");
   property p_t1h_ack;
      psel && !penable && paddr == A_T1H |=> pready && !pslverr;
   endproperty
   a_t1h_ack: assert property (p_t1h_ack) else $error("t1 high not answered");
   property p_mode_rd;
      ra && paddr == A_MD |-> prdata == {24'h000000, md_sh};
   endproperty
   a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
   property p_hold0;
      ra && paddr == A_T0L && v0 |-> prdata[7:0] == t0l_sh;
   endproperty
   a_hold0: assert property (p_hold0) else $error("t0 low moved while stopped");
   property p_hold1;
      ra && paddr == A_T1H && v1 |-> prdata[7:0] == t1h_sh;
   endproperty
   a_hold1: assert property (p_hold1) else $error("t1 high moved while stopped");
   property p_upper;
      ra |-> prdata[31:8] == 24'h000000;
   endproperty
   a_upper: assert property (p_upper) else $error("read upper bits set");
   c_run: cover property (wa && paddr == A_FL && pwdata[4]);
   c_err: cover property (pready && pslverr);
   c_held: cover property (v0 && v1);
endmodule
bind dual_timer_counter timer_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);
`default_nettype wire
